/* core/compact_timer_pkg.sv */
// Package with register map, field layouts and timing constants of the compact timer
// Function
// - Comparators A and P each raise interrupts
// - Ten-bit up-counter on internal or external clock
// - P checks top three bits, A all ten
// - Software only clears counter via run rising
// - Counter self-clears on overflow or selected match
// - Counter read-only pair, compare A read/write pair
// - Low byte write fills holding buffer only
// - High byte write also copies buffer to low
// - High byte read captures low into buffer
// - Low byte read returns holding buffer
// - Second output pin is inverse of first
// - Pins set, clear, toggle or carry PWM
// - Pause bit freezes counter, keeps value
// - Clock codes pick system clock, divided or not, or sub clock
// - Codes 110/111 count external rising/falling edges
// - Control register 0 resets to zero
// - Run rising clears counter, restores pin level
// - Period field in 128-clock steps, 000 overflow
// - Clear select picks A or P, PWM ignores
// - Mode field: compare, PWM, timer, 01 undefined
package compact_timer_pkg;

  localparam int CNT_W = 10;
  localparam int PER_W = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL_0 = 8'h00;
  localparam logic [7:0] OFS_CONTROL_1 = 8'h04;
  localparam logic [7:0] OFS_CNT_LOW   = 8'h08;
  localparam logic [7:0] OFS_CNT_HIGH  = 8'h0C;
  localparam logic [7:0] OFS_CMPA_LOW  = 8'h10;
  localparam logic [7:0] OFS_CMPA_HIGH = 8'h14;

  localparam logic [7:0] CONTROL_0_RESET = 8'h00;
  localparam logic [7:0] CONTROL_1_RESET = 8'h00;

  // Clock select codes
  localparam logic [2:0] CLK_SYS_DIV4  = 3'h0;
  localparam logic [2:0] CLK_SYS       = 3'h1;
  localparam logic [2:0] CLK_HIGH_D16  = 3'h2;
  localparam logic [2:0] CLK_HIGH_D64  = 3'h3;
  localparam logic [2:0] CLK_SUB_A     = 3'h4;
  localparam logic [2:0] CLK_SUB_B     = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE  = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL  = 3'h7;

  // Prescaler masks for the divided clocks
  localparam int PRE_W = 6;
  localparam logic [5:0] DIV4_MASK  = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0F;
  localparam logic [5:0] DIV64_MASK = 6'h3F;

  // Operating modes
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;

  // Pin actions
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  typedef struct packed {
    logic       pause_bit;
    logic [2:0] clock_select_field;
    logic       run_enable_bit;
    logic [2:0] period_compare_field;
  } control_0_t;

  typedef struct packed {
    logic [1:0] operating_mode_field;
    logic [1:0] pin_action_field;
    logic       out_initial;
    logic       out_invert;
    logic       pwm_swap;
    logic       clear_source_select;
  } control_1_t;

endpackage

/* core/compact_timer.sv */
// Ten-bit compact timer with APB register access and waveform pins
`timescale 1ns/100ps
module compact_timer
  import compact_timer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // APB
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Clock pins
  input  wire logic              external_clock_pin,
  input  wire logic              sub_clock,
  // Waveform pins
  output logic                   waveform_out_pin,
  output logic                   waveform_out_inverted_pin,
  // Interrupt requests
  output logic                   irq_compare_a,
  output logic                   irq_compare_p
);

  if (ADDR_W < 8) begin : g_check
    $error("compact_timer: ADDR_W must be at least 8");
  end

  control_0_t         ctrl0;
  control_1_t         ctrl1;
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W-1:0]   compare_a_value;
  logic [7:0]         hold;
  logic [7:0]         snap;
  logic               run_prev;
  logic               out_level;
  logic [PRE_W-1:0]   pre;
  logic [1:0]         pin_rise;
  logic [1:0]         pin_fall;
  logic               tick;
  logic               run_rise;
  logic [CNT_W:0]     next_cnt;
  logic               a_match;
  logic               p_match;
  logic               do_clear;
  logic               setup;
  logic               access;
  logic               mapped;
  logic [7:0]         rd_byte;
  logic [7:0]         addr8;

  assign addr8 = paddr[7:0];

  // Pin synchronisers with agreement filter
  logic [1:0] pin_in;
  assign pin_in = {sub_clock, external_clock_pin};

  for (genvar i = 0; i < 2; i++) begin : g_pin
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1  <= 1'b0;
        s2  <= 1'b0;
        s3  <= 1'b0;
        lvl <= 1'b0;
      end else begin
        s1 <= pin_in[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          lvl <= s3;
        end
      end
    end
    assign pin_rise[i] = (s2 == s3) && s3 && !lvl;
    assign pin_fall[i] = (s2 == s3) && !s3 && lvl;
  end

  // Prescaler for divided internal clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= '0;
    end else begin
      pre <= pre + 6'h01;
    end
  end

  // Counting tick from the selected source
  always_comb begin
    case (ctrl0.clock_select_field)
      CLK_SYS_DIV4: tick = (pre & DIV4_MASK) == DIV4_MASK;
      CLK_SYS:      tick = 1'b1;
      CLK_HIGH_D16: tick = (pre & DIV16_MASK) == DIV16_MASK;
      CLK_HIGH_D64: tick = (pre & DIV64_MASK) == DIV64_MASK;
      CLK_SUB_A,
      CLK_SUB_B:    tick = pin_rise[1];
      CLK_EXT_RISE: tick = pin_rise[0];
      CLK_EXT_FALL: tick = pin_fall[0];
      default:      tick = 1'b0;
    endcase
  end

  logic count_en;
  assign count_en = ctrl0.run_enable_bit && !ctrl0.pause_bit && tick;
  assign run_rise = ctrl0.run_enable_bit && !run_prev;
  assign next_cnt = {1'b0, cnt} + 11'h001;

  // Comparators, evaluated on the value the counter is about to reach
  assign a_match = count_en && (next_cnt[CNT_W-1:0] == compare_a_value);
  always_comb begin
    if (ctrl0.period_compare_field == 3'h0) begin
      p_match = count_en && next_cnt[CNT_W];
    end else begin
      p_match = count_en && (next_cnt[9:7] == ctrl0.period_compare_field)
                && (next_cnt[6:0] == 7'h00);
    end
  end

  // Clear source: PWM clears on its period comparator
  always_comb begin
    if (ctrl1.operating_mode_field == MODE_PWM) begin
      do_clear = ctrl1.pwm_swap ? a_match : p_match;
    end else begin
      do_clear = ctrl1.clear_source_select ? a_match : p_match;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_prev <= 1'b0;
    end else begin
      run_prev <= ctrl0.run_enable_bit;
    end
  end

  // Counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (run_rise) begin
      cnt <= '0;
    end else if (count_en) begin
      cnt <= do_clear ? '0 : next_cnt[CNT_W-1:0];
    end
  end

  // Interrupt pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_compare_a <= 1'b0;
      irq_compare_p <= 1'b0;
    end else begin
      irq_compare_a <= a_match;
      irq_compare_p <= p_match;
    end
  end

  // Output level
  logic pwm_active;
  always_comb begin
    if (ctrl1.pwm_swap) begin
      pwm_active = cnt[9:7] < ctrl0.period_compare_field;
    end else begin
      pwm_active = cnt < compare_a_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_level <= 1'b0;
    end else if (run_rise) begin
      out_level <= ctrl1.out_initial;
    end else begin
      case (ctrl1.operating_mode_field)
        MODE_COMPARE: begin
          if (a_match) begin
            case (ctrl1.pin_action_field)
              ACT_LOW:    out_level <= 1'b0;
              ACT_HIGH:   out_level <= 1'b1;
              ACT_TOGGLE: out_level <= !out_level;
              default:    out_level <= out_level;
            endcase
          end
        end
        MODE_PWM: begin
          case (ctrl1.pin_action_field)
            2'h0:    out_level <= !ctrl1.out_initial;
            2'h1:    out_level <= ctrl1.out_initial;
            2'h2:    out_level <= pwm_active ? ctrl1.out_initial : !ctrl1.out_initial;
            default: out_level <= out_level;
          endcase
        end
        default: out_level <= out_level;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_out_pin          <= 1'b0;
      waveform_out_inverted_pin <= 1'b1;
    end else begin
      waveform_out_pin          <= out_level ^ ctrl1.out_invert;
      waveform_out_inverted_pin <= !(out_level ^ ctrl1.out_invert);
    end
  end

  // APB slave, zero wait states
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign mapped  = (paddr[ADDR_W-1:0] >> 8) == '0 &&
                   (addr8 == OFS_CONTROL_0 || addr8 == OFS_CONTROL_1 ||
                    addr8 == OFS_CNT_LOW   || addr8 == OFS_CNT_HIGH  ||
                    addr8 == OFS_CMPA_LOW  || addr8 == OFS_CMPA_HIGH);
  assign pslverr = access && !mapped;

  logic wr_acc;
  assign wr_acc = access && pwrite && mapped;

  always_comb begin
    case (addr8)
      OFS_CONTROL_0: rd_byte = ctrl0;
      OFS_CONTROL_1: rd_byte = ctrl1;
      OFS_CNT_LOW,
      OFS_CMPA_LOW:  rd_byte = hold;
      OFS_CNT_HIGH:  rd_byte = {6'h00, cnt[9:8]};
      OFS_CMPA_HIGH: rd_byte = {6'h00, compare_a_value[9:8]};
      default:       rd_byte = 8'h00;
    endcase
  end

  // Read data and low-byte snapshot taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      snap   <= 8'h00;
    end else if (setup) begin
      prdata <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      snap   <= (addr8 == OFS_CNT_HIGH) ? cnt[7:0] : compare_a_value[7:0];
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0 <= CONTROL_0_RESET;
      ctrl1 <= CONTROL_1_RESET;
    end else if (wr_acc) begin
      if (addr8 == OFS_CONTROL_0) begin
        ctrl0 <= pwdata[7:0];
      end
      if (addr8 == OFS_CONTROL_1) begin
        ctrl1 <= pwdata[7:0];
      end
    end
  end

  // Holding buffer and compare A value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold            <= 8'h00;
      compare_a_value <= '0;
    end else if (access && mapped) begin
      if (pwrite && addr8 == OFS_CMPA_LOW) begin
        hold <= pwdata[7:0];
      end
      if (pwrite && addr8 == OFS_CMPA_HIGH) begin
        compare_a_value <= {pwdata[1:0], hold};
      end
      if (!pwrite && (addr8 == OFS_CNT_HIGH || addr8 == OFS_CMPA_HIGH)) begin
        hold <= snap;
      end
    end
  end

  // Assertions
  a_run_rise_clear: assert property (@(posedge pclk) disable iff (!presetn)
    run_rise |=> cnt == '0) else $error("counter not cleared on run rising");

  a_pause_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl0.pause_bit && !run_rise) |=> $stable(cnt)) else $error("counter moved in pause");

  a_off_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl0.run_enable_bit |=> $stable(cnt)) else $error("counter moved while off");

  a_irq_a_cause: assert property (@(posedge pclk) disable iff (!presetn)
    irq_compare_a == $past(a_match)) else $error("compare A request mismatch");

  a_irq_p_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_compare_p && ctrl0.period_compare_field != 3'h0 && $stable(ctrl0))
      |=> !irq_compare_p) else $error("compare P request longer than one cycle");

  a_pins_inverse: assert property (@(posedge pclk) disable iff (!presetn)
    waveform_out_inverted_pin == !waveform_out_pin) else $error("pins not complementary");

  a_low_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && addr8 == OFS_CMPA_LOW)
      |=> hold == $past(pwdata[7:0]) && $stable(compare_a_value))
    else $error("low byte write reached compare value");

  a_high_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && addr8 == OFS_CMPA_HIGH)
      |=> compare_a_value == {$past(pwdata[1:0]), $past(hold)})
    else $error("high byte write did not merge buffer");

  a_high_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && addr8 == OFS_CMPA_HIGH) ##1 access
      |=> hold == $past(compare_a_value[7:0], 2)) else $error("high read missed capture");

  a_low_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && addr8 == OFS_CNT_LOW)
      |=> prdata == {24'h00_0000, $past(hold)}) else $error("low read not from buffer");

  a_period_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (p_match && !run_rise && ctrl1.operating_mode_field != MODE_PWM
      && !ctrl1.clear_source_select) |=> cnt == '0) else $error("period match did not clear");

  a_cmp_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (a_match && !run_rise && ctrl1.operating_mode_field == MODE_COMPARE
      && ctrl1.pin_action_field == ACT_TOGGLE) |=> out_level != $past(out_level))
    else $error("toggle action missing");

  a_irq_p_cause: assert property (@(posedge pclk) disable iff (!presetn)
    irq_compare_p == $past(p_match)) else $error("compare P request mismatch");

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (count_en && !do_clear && !run_rise) |=> cnt == $past(cnt) + 10'h001)
    else $error("counter did not advance by one");

  a_clear_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (a_match && !run_rise && ctrl1.operating_mode_field != MODE_PWM
      && ctrl1.clear_source_select) |=> cnt == '0)
    else $error("compare A match did not clear");

  a_overflow_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (count_en && cnt == '1 && !run_rise) |=> cnt == '0) else $error("counter overflow not cleared");

  a_run_pin_init: assert property (@(posedge pclk) disable iff (!presetn)
    run_rise |=> out_level == $past(ctrl1.out_initial)) else $error("pin level not restored");

  a_timer_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl1.operating_mode_field == MODE_TIMER && !run_rise) |=> $stable(out_level))
    else $error("pin level moved in timer mode");

  a_pwm_inactive: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl1.operating_mode_field == MODE_PWM && ctrl1.pin_action_field == 2'h0 && !run_rise)
      |=> out_level != $past(ctrl1.out_initial)) else $error("PWM inactive level wrong");

  a_cnt_high_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && addr8 == OFS_CNT_HIGH) ##1 access
      |=> hold == $past(cnt[7:0], 2)) else $error("counter high read missed capture");

  a_div4_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (count_en && ctrl0.clock_select_field == CLK_SYS_DIV4 && !wr_acc) |=> !count_en)
    else $error("divided clock ticked twice in a row");

  a_pause_no_match: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl0.pause_bit |-> !a_match && !p_match) else $error("match seen while paused");

  a_cmp_high: assert property (@(posedge pclk) disable iff (!presetn)
    (a_match && !run_rise && ctrl1.operating_mode_field == MODE_COMPARE
      && ctrl1.pin_action_field == ACT_HIGH) |=> out_level)
    else $error("set-high action missing");

  a_cmp_low: assert property (@(posedge pclk) disable iff (!presetn)
    (a_match && !run_rise && ctrl1.operating_mode_field == MODE_COMPARE
      && ctrl1.pin_action_field == ACT_LOW) |=> !out_level)
    else $error("set-low action missing");

endmodule // compact_timer

/* verif/pin_partner.sv */
// Model of the clock sources that feed the timer pins
`timescale 1ns/100ps
module pin_partner (
  // Bench control
  input  wire logic pclk,
  input  wire logic burst,
  // Pins
  output logic      external_clock_pin,
  output logic      sub_clock
);
  int   left  = 0;
  int   step  = 0;
  logic level = 1'b0;
  assign external_clock_pin = level;
  // Free sub clock, 80 ns, phase unrelated to pclk
  initial begin
    sub_clock = 1'b0;
    #3;
    forever #40 sub_clock = ~sub_clock;
  end
  // Burst of ten toggles, four cycles apart, ends low and then stands still
  always @(posedge pclk) begin
    if (burst) begin
      left <= 10;
      step <= 0;
    end else if (left != 0) begin
      step <= (step == 3) ? 0 : step + 1;
      if (step == 3) begin
        level <= ~level;
        left  <= left - 1;
      end
    end
  end
endmodule // pin_partner

/* verif/testbench.sv */
// Self-checking bench for the compact timer over APB
`timescale 1ns/100ps
module testbench;
  import compact_timer_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        ext_pin;
  logic        sub_clk;
  logic        pin;
  logic        pin_n;
  logic        pin_old = 1'b0;
  logic        irq_a;
  logic        irq_p;
  logic        burst;
  logic        serr;
  logic [31:0] rd;
  logic [31:0] v1;
  logic [31:0] v2;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycle = 0;
  int          toggles = 0;
  int          a_hits = 0;
  int          highs = 0;
  int          h1;
  int          t;
  int          divs [6] = '{4, 1, 16, 64, 8, 8};
  logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h0C, 8'h08, 8'h14, 8'h10};
  logic [7:0]  c1v [2] = '{8'h21, 8'h19};

  compact_timer #(.ADDR_W(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .external_clock_pin(ext_pin),
    .sub_clock(sub_clk), .waveform_out_pin(pin), .waveform_out_inverted_pin(pin_n),
    .irq_compare_a(irq_a), .irq_compare_p(irq_p));
  pin_partner u_pins (
    .pclk(pclk), .burst(burst), .external_clock_pin(ext_pin), .sub_clock(sub_clk));

  always #5 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  // High byte first, so the low byte comes from the snapshot
  task automatic rd10(output logic [31:0] v);
    apb(1'b0, OFS_CNT_HIGH, 8'h00);
    v = {rd[23:0], 8'h00};
    apb(1'b0, OFS_CNT_LOW, 8'h00);
    v = v | rd;
  endtask

  task automatic wait_irq(input logic sel_p, output int at);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((sel_p ? irq_p : irq_a) !== 1'b1 && n < 3000);
    if ((sel_p ? irq_p : irq_a) !== 1'b1) err_count++;
    at = cycle;
  endtask

  task automatic gap(input logic sel_p, input int exp);
    int t1;
    int t2;
    wait_irq(sel_p, t1);
    wait_irq(sel_p, t2);
    chk(t2 - t1, exp);
  endtask

  always @(posedge pclk) begin
    cycle <= cycle + 1;
    if (cycle == 40000) begin
      err_count++;
      wrap_up();
    end
  end

  always @(negedge pclk) begin
    if (presetn === 1'b1) chk({31'h0, pin_n}, {31'h0, ~pin});
    if (pin !== pin_old) toggles++;
    if (pin === 1'b1) highs++;
    if (irq_a === 1'b1) a_hits++;
    pin_old = pin;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    burst = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rc(ofs[i], 32'h0000_0000);
    wr(8'h18, 8'hFF);
    chk({31'h0, serr}, 32'h1);
    wr(OFS_CNT_LOW, 8'h55);
    rc(OFS_CNT_HIGH, 32'h0000_0000);
    rc(OFS_CNT_LOW, 32'h0000_0000);
    wr(OFS_CMPA_LOW, 8'h34);
    rc(OFS_CMPA_HIGH, 32'h0000_0000);
    rc(OFS_CMPA_LOW, 32'h0000_0000);
    wr(OFS_CMPA_LOW, 8'h34);
    wr(OFS_CMPA_HIGH, 8'h02);
    rc(OFS_CMPA_HIGH, 32'h0000_0002);
    rc(OFS_CMPA_LOW, 32'h0000_0034);
    wr(OFS_CMPA_LOW, 8'h10);
    wr(OFS_CMPA_HIGH, 8'h00);
    wr(OFS_CONTROL_1, 8'hC1);
    for (int k = 0; k < 6; k++) begin
      wr(OFS_CONTROL_0, {1'b0, 3'(k), 1'b1, 3'h0});
      gap(1'b0, 16 * divs[k]);
      wr(OFS_CONTROL_0, 8'h00);
    end
    wr(OFS_CONTROL_1, 8'hC0);
    wr(OFS_CONTROL_0, 8'h19);
    gap(1'b1, 128);
    wr(OFS_CONTROL_0, 8'h18);
    gap(1'b1, 1024);
    gap(1'b0, 1024);
    wr(OFS_CONTROL_0, 8'h98);
    rd10(v1);
    repeat (20) @(posedge pclk);
    rd10(v2);
    chk(v2, v1);
    wr(OFS_CONTROL_0, 8'h18);
    rd10(v2);
    chk({31'h0, v2 !== v1}, 32'h1);
    wr(OFS_CONTROL_0, 8'h10);
    rd10(v1);
    repeat (20) @(posedge pclk);
    rd10(v2);
    chk(v2, v1);
    wr(OFS_CONTROL_0, 8'h98);
    rd10(v2);
    chk(v2, 32'h0000_0000);
    for (int k = 6; k < 8; k++) begin
      wr(OFS_CONTROL_0, 8'h00);
      wr(OFS_CONTROL_0, {1'b0, 3'(k), 1'b1, 3'h0});
      @(posedge pclk);
      burst <= 1'b1;
      @(posedge pclk);
      burst <= 1'b0;
      repeat (60) @(posedge pclk);
      rd10(v2);
      chk(v2, 32'h0000_0005);
    end
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_CONTROL_1, 8'h31);
    toggles = 0;
    a_hits = 0;
    wr(OFS_CONTROL_0, 8'h18);
    repeat (200) @(posedge pclk);
    wr(OFS_CONTROL_0, 8'h98);
    repeat (4) @(posedge pclk);
    chk(toggles, a_hits);
    chk({31'h0, a_hits > 8}, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CONTROL_0, 8'h10);
      wr(OFS_CONTROL_1, c1v[i]);
      wr(OFS_CONTROL_0, 8'h18);
      repeat (3) @(negedge pclk);
      chk({31'h0, pin}, {31'h0, c1v[i][3]});
      wait_irq(1'b0, t);
      repeat (3) @(negedge pclk);
      chk({31'h0, pin}, {31'h0, ~c1v[i][3]});
    end
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_CONTROL_1, 8'hA8);
    wr(OFS_CONTROL_0, 8'h18);
    wait_irq(1'b1, t);
    #1;
    h1 = highs;
    wait_irq(1'b1, t);
    #1;
    chk(highs - h1, 16);
    // Swapped PWM: compare A sets the period, pin inverted
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_CMPA_LOW, 8'h00);
    wr(OFS_CMPA_HIGH, 8'h02);
    wr(OFS_CONTROL_1, 8'hAE);
    wr(OFS_CONTROL_0, 8'h19);
    wait_irq(1'b0, t);
    #1;
    h1 = highs;
    wait_irq(1'b0, t);
    #1;
    chk(highs - h1, 384);
    wr(OFS_CONTROL_1, 8'h88);
    repeat (3) @(negedge pclk);
    chk({31'h0, pin}, 32'h0);
    wr(OFS_CONTROL_1, 8'h98);
    repeat (3) @(negedge pclk);
    chk({31'h0, pin}, 32'h1);
    wrap_up();
  end
endmodule // testbench
